// ### hdl/mlt_pkg.sv
// Constants of the MAC address lookup table
package mlt_pkg;
   // ------------------------------------------------
   // Table geometry
   // ------------------------------------------------
   localparam int unsigned BKT_W = 10;
   localparam int unsigned ADR_W = 12;
   localparam int unsigned ENT_W = 72;
   localparam logic [12:0] LAST_ADR = 13'h0FFF;
   localparam logic [2:0] WAYS = 3'h4;
   localparam logic [2:0] AFULL_MIN = 3'h2;
   localparam logic [2:0] AGE_RELOAD = 3'h4;
   // ------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------
   localparam logic [15:0] LKCTL_OFS = 16'h0400;
   localparam logic [15:0] IDX0_OFS = 16'h0410;
   localparam logic [15:0] IDX1_OFS = 16'h0414;
   localparam logic [15:0] ACC_OFS = 16'h0418;
   localparam logic [15:0] EVT_OFS = 16'h041C;
   localparam logic [15:0] ENT1_OFS = 16'h0420;
   localparam logic [15:0] ENT2_OFS = 16'h0424;
   localparam logic [15:0] ENT3_OFS = 16'h0428;
   localparam logic [15:0] ENT4_OFS = 16'h042C;
   // ------------------------------------------------
   // Register fields
   // ------------------------------------------------
   localparam int unsigned ACC_GO = 7;
   localparam int unsigned ACC_DIRECT = 2;
   localparam int unsigned EVT_AFULL = 0;
   localparam int unsigned EVT_WFAIL = 1;
   localparam int unsigned EVT_LFAIL = 2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_SEARCH = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------
   // Stored entry layout
   // ------------------------------------------------
   localparam int unsigned E_STATIC = 71;
   localparam int unsigned E_SRCF = 70;
   localparam int unsigned E_DESF = 69;
   localparam int unsigned E_AGE = 66;
   localparam int unsigned E_MSTP = 63;
   localparam int unsigned E_OVR = 62;
   localparam int unsigned E_FWD = 55;
   localparam int unsigned E_FID = 48;
   // ------------------------------------------------
   // Engine states
   // ------------------------------------------------
   typedef enum logic [4:0] {
      ST_CLR = 5'b00001,
      ST_IDLE = 5'b00010,
      ST_SEARCH = 5'b00100,
      ST_SHOLD = 5'b01000,
      ST_AGE = 5'b10000
   } mlt_state_t;
endpackage : mlt_pkg

// ### hdl/mlt_lookup_table.sv
// MAC address lookup table with indirect host access over AXI4-Lite
// How it works
// - 4096 entries as 1024 buckets of four ways.
// - MAC, optionally with group id, hashes to a 10-bit bucket.
// - New entry fills a free way, else replaces least used dynamic way.
// - Static add into bucket with 2-3 statics flags almost-full, address in index0.
// - Static write into four-static bucket fails, flags, bucket in index0.
// - Four-static bucket blocks learning, flags learn-fail, bucket in index1.
// - Destination lookups merge all tables; source lookups learn and refresh here.
// - Static destination result beats a dynamic one.
// - Aging never touches static entries.
// - Host reads any entry, writes static entries only.
// - Host access by hash, by direct address, or sequential search.
// - Host starts with operation code, direct bit and go flag.
// - Read clears go; found bit then shows a valid entry.
// - Combined bit is found or not busy.
// - No entry found leaves all four entry registers zero.
// - Search starts at address zero, clears found, skips invalid entries.
// - Reading the fourth entry register resumes the search.
// - Go stays set until search ends; writing go low aborts.
// - Search keeps a count of valid entries returned.
// - Entry one bit 31 is the static flag.
// - Dynamic age reloads on learn or access, decrements; zero means invalid.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module mlt_lookup_table
   import mlt_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lk_valid,
   output logic lk_ready,
   input wire logic lk_is_src,
   input wire logic [47:0] lk_mac,
   input wire logic [6:0] lk_fid,
   input wire logic [6:0] lk_src_mask,
   input wire logic ext_static_hit,
   input wire logic [6:0] ext_static_fwd,
   input wire logic age_tick,
   output logic res_valid,
   output logic res_hit,
   output logic res_static,
   output logic [6:0] res_fwd,
   output logic res_drop
);
   // ------------------------------------------------
   // Storage and state
   // ------------------------------------------------
   logic [ENT_W-1:0] mem [0:4095];
   mlt_state_t st_ff;
   logic [12:0] ptr_ff;
   logic go_ff;
   logic [1:0] act_ff;
   logic direct_ff;
   logic found_ff;
   logic [12:0] cnt_ff;
   logic [ENT_W-1:0] ent_ff;
   logic [22:0] idx0_ff;
   logic [31:0] idx1_ff;
   logic [2:0] lkctl_ff;
   logic [2:0] evt_ff;
   logic age_pend_ff;
   logic aw_hold_ff;
   logic w_hold_ff;
   logic [15:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic res_valid_ff;
   logic res_hit_ff;
   logic res_static_ff;
   logic [6:0] res_fwd_ff;
   logic res_drop_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rdata_ff;

   function automatic logic ent_ok(input logic [ENT_W-1:0] e);
      return e[E_STATIC] | (e[E_AGE+:3] != 3'h0);
   endfunction : ent_ok

   function automatic logic [9:0] hash10(input logic [47:0] m, input logic [6:0] f, input logic [2:0] c);
      logic [9:0] fold;
      logic [9:0] k;
      fold = m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ {2'h0, m[47:40]};
      k = c[2] ? {3'h0, f} : 10'h000;
      case (c[1:0])
         2'h1: hash10 = m[9:0] ^ k;
         2'h2: hash10 = {fold[4:0], fold[9:5]} ^ k;
         default: hash10 = fold ^ k;
      endcase
   endfunction : hash10

   // ------------------------------------------------
   // Bucket analysis
   // ------------------------------------------------
   logic host_op;
   logic lk_fire;
   logic [47:0] key_mac;
   logic [6:0] key_fid;
   logic [9:0] bucket;
   logic hit;
   logic [1:0] hit_way;
   logic [2:0] nstat;
   logic has_free;
   logic [1:0] free_way;
   logic [1:0] lru_way;
   logic [2:0] lru_age;
   logic [1:0] tgt_way;
   logic blocked;
   logic [ENT_W-1:0] hit_ent;
   logic [ENT_W-1:0] dir_ent;
   logic [ENT_W-1:0] cur_ent;

   assign host_op = (st_ff == ST_IDLE) && go_ff;
   assign lk_ready = (st_ff == ST_IDLE) && !go_ff && !age_pend_ff;
   assign lk_fire = lk_valid && lk_ready;

   always_comb begin
      key_mac = lk_mac;
      key_fid = lk_fid;
      if (host_op && act_ff == OP_WRITE) begin
         key_mac = ent_ff[47:0];
         key_fid = ent_ff[E_FID+:7];
      end else if (host_op) begin
         key_mac = {idx0_ff[15:0], idx1_ff};
         key_fid = idx0_ff[22:16];
      end
   end

   assign bucket = hash10(key_mac, key_fid, lkctl_ff);

   always_comb begin
      logic [ENT_W-1:0] e;
      e = '0;
      hit = 1'b0;
      hit_way = 2'h0;
      nstat = 3'h0;
      has_free = 1'b0;
      free_way = 2'h0;
      lru_way = 2'h0;
      lru_age = 3'h7;
      for (int w = 3; w >= 0; w--) begin
         e = mem[{bucket, 2'(w)}];
         if (ent_ok(e) && e[47:0] == key_mac && (!lkctl_ff[2] || e[E_FID+:7] == key_fid)) begin
            hit = 1'b1;
            hit_way = 2'(w);
         end
         if (e[E_STATIC]) begin
            nstat = nstat + 3'h1;
         end
         if (!ent_ok(e)) begin
            has_free = 1'b1;
            free_way = 2'(w);
         end else if (!e[E_STATIC] && e[E_AGE+:3] <= lru_age) begin
            lru_way = 2'(w);
            lru_age = e[E_AGE+:3];
         end
      end
   end

   assign tgt_way = hit ? hit_way : (has_free ? free_way : lru_way);
   assign blocked = !hit && (nstat == WAYS);
   assign hit_ent = mem[{bucket, hit_way}];
   assign dir_ent = mem[idx1_ff[ADR_W-1:0]];
   assign cur_ent = mem[ptr_ff[ADR_W-1:0]];

   // ------------------------------------------------
   // Table write port
   // ------------------------------------------------
   logic mem_we;
   logic [ADR_W-1:0] mem_wa;
   logic [ENT_W-1:0] mem_wd;

   always_comb begin
      mem_we = 1'b0;
      mem_wa = ptr_ff[ADR_W-1:0];
      mem_wd = '0;
      unique case (st_ff)
         ST_CLR: begin
            mem_we = 1'b1;
         end
         ST_AGE: begin
            mem_wd = cur_ent;
            mem_wd[E_AGE+:3] = cur_ent[E_AGE+:3] - 3'h1;
            mem_we = !cur_ent[E_STATIC] && cur_ent[E_AGE+:3] != 3'h0;
         end
         ST_IDLE: begin
            if (host_op) begin
               mem_wd = ent_ff;
               mem_wa = direct_ff ? idx1_ff[ADR_W-1:0] : {bucket, tgt_way};
               mem_we = act_ff == OP_WRITE && ent_ff[E_STATIC] && (direct_ff || !blocked);
            end else if (lk_fire && hit) begin
               mem_wa = {bucket, hit_way};
               mem_wd = hit_ent;
               mem_wd[E_AGE+:3] = AGE_RELOAD;
               if (lk_is_src) begin
                  mem_wd[E_FWD+:7] = lk_src_mask;
               end
               mem_we = !hit_ent[E_STATIC];
            end else if (lk_fire && lk_is_src) begin
               mem_wa = {bucket, tgt_way};
               mem_wd[E_AGE+:3] = AGE_RELOAD;
               mem_wd[E_FWD+:7] = lk_src_mask;
               mem_wd[E_FID+:7] = lk_fid;
               mem_wd[47:0] = lk_mac;
               mem_we = !blocked;
            end
         end
         ST_SEARCH, ST_SHOLD: begin
            mem_we = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // ------------------------------------------------
   // Register view
   // ------------------------------------------------
   function automatic logic reg_rd(input logic [15:0] a, output logic [31:0] d);
      reg_rd = 1'b1;
      d = 32'h0000_0000;
      case (a)
         LKCTL_OFS: d = {29'h0, lkctl_ff};
         IDX0_OFS: d = {9'h0, idx0_ff};
         IDX1_OFS: d = idx1_ff;
         ACC_OFS: d = {3'h0, cnt_ff, 8'h00, go_ff, 2'h0, found_ff | !go_ff, found_ff, direct_ff, act_ff};
         EVT_OFS: d = {29'h0, evt_ff};
         ENT1_OFS: d = {ent_ff[E_STATIC-:6], 23'h0, ent_ff[E_MSTP+:3]};
         ENT2_OFS: d = {ent_ff[E_OVR], 24'h0, ent_ff[E_FWD+:7]};
         ENT3_OFS: d = {9'h0, ent_ff[E_FID+:7], ent_ff[47:32]};
         ENT4_OFS: d = ent_ff[31:0];
         default: reg_rd = 1'b0;
      endcase
   endfunction : reg_rd

   logic wr_fire;
   logic wr_ok;
   logic [31:0] wr_old;
   logic [31:0] wd;
   logic ar_fire;
   logic rd_ok;
   logic [31:0] rd_val;
   logic rd_ent4;

   assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign ar_fire = s_axi_arvalid && !rvalid_ff;
   assign rd_ent4 = ar_fire && s_axi_araddr == ENT4_OFS;

   always_comb begin
      wr_ok = reg_rd(awaddr_ff, wr_old);
      for (int b = 0; b < 4; b++) begin
         wd[b*8+:8] = wstrb_ff[b] ? wdata_ff[b*8+:8] : wr_old[b*8+:8];
      end
      rd_ok = reg_rd(s_axi_araddr, rd_val);
   end

   // ------------------------------------------------
   // Bus handshake
   // ------------------------------------------------
   assign s_axi_awready = !aw_hold_ff;
   assign s_axi_wready = !w_hold_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= 16'h0000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_hold_ff) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[15:2], 2'h0};
         end
         if (s_axi_wvalid && !w_hold_ff) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= 32'h0000_0000;
      end else if (ar_fire) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         rdata_ff <= rd_val;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ------------------------------------------------
   // Engine and registers
   // ------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_ff <= ST_CLR;
         ptr_ff <= 13'h0000;
         go_ff <= 1'b0;
         act_ff <= 2'h0;
         direct_ff <= 1'b0;
         found_ff <= 1'b0;
         cnt_ff <= 13'h0000;
         ent_ff <= '0;
         idx0_ff <= 23'h00_0000;
         idx1_ff <= 32'h0000_0000;
         lkctl_ff <= 3'h0;
         evt_ff <= 3'h0;
         age_pend_ff <= 1'b0;
         res_valid_ff <= 1'b0;
         res_hit_ff <= 1'b0;
         res_static_ff <= 1'b0;
         res_fwd_ff <= 7'h00;
         res_drop_ff <= 1'b0;
      end else begin
         res_valid_ff <= 1'b0;
         if (wr_fire) begin
            case (awaddr_ff)
               LKCTL_OFS: lkctl_ff <= wd[2:0];
               IDX0_OFS: idx0_ff <= wd[22:0];
               IDX1_OFS: idx1_ff <= wd;
               EVT_OFS: evt_ff <= evt_ff & ~wd[2:0];
               ENT1_OFS: begin
                  ent_ff[E_STATIC-:6] <= wd[31:26];
                  ent_ff[E_MSTP+:3] <= wd[2:0];
               end
               ENT2_OFS: begin
                  ent_ff[E_OVR] <= wd[31];
                  ent_ff[E_FWD+:7] <= wd[6:0];
               end
               ENT3_OFS: begin
                  ent_ff[E_FID+:7] <= wd[22:16];
                  ent_ff[47:32] <= wd[15:0];
               end
               ENT4_OFS: ent_ff[31:0] <= wd;
               ACC_OFS: begin
                  if (!go_ff) begin
                     act_ff <= wd[1:0];
                     direct_ff <= wd[ACC_DIRECT];
                     go_ff <= wd[ACC_GO];
                  end
               end
               default: begin
               end
            endcase
         end
         unique case (st_ff)
            ST_CLR, ST_AGE: begin
               ptr_ff <= ptr_ff + 13'h0001;
               if (ptr_ff == LAST_ADR) begin
                  ptr_ff <= 13'h0000;
                  st_ff <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (go_ff) begin
                  unique case (act_ff)
                     OP_READ: begin
                        found_ff <= direct_ff ? ent_ok(dir_ent) : hit;
                        ent_ff <= '0;
                        if (direct_ff && ent_ok(dir_ent)) begin
                           ent_ff <= dir_ent;
                        end else if (!direct_ff && hit) begin
                           ent_ff <= hit_ent;
                        end
                        go_ff <= 1'b0;
                     end
                     OP_WRITE: begin
                        go_ff <= 1'b0;
                        if (ent_ff[E_STATIC] && !direct_ff && blocked) begin
                           evt_ff[EVT_WFAIL] <= 1'b1;
                           idx0_ff[9:0] <= bucket;
                        end else if (ent_ff[E_STATIC] && !direct_ff && !hit && nstat >= AFULL_MIN) begin
                           evt_ff[EVT_AFULL] <= 1'b1;
                           idx0_ff[11:0] <= {bucket, tgt_way};
                        end
                     end
                     OP_SEARCH: begin
                        found_ff <= 1'b0;
                        cnt_ff <= 13'h0000;
                        ptr_ff <= 13'h0000;
                        st_ff <= ST_SEARCH;
                     end
                     default: go_ff <= 1'b0;
                  endcase
               end else if (age_pend_ff) begin
                  age_pend_ff <= 1'b0;
                  ptr_ff <= 13'h0000;
                  st_ff <= ST_AGE;
               end else if (lk_fire) begin
                  res_valid_ff <= 1'b1;
                  res_hit_ff <= hit || (!lk_is_src && ext_static_hit);
                  res_static_ff <= hit && hit_ent[E_STATIC];
                  res_fwd_ff <= hit ? hit_ent[E_FWD+:7] : 7'h00;
                  res_drop_ff <= hit && (lk_is_src ? hit_ent[E_SRCF] : hit_ent[E_DESF]);
                  if (!lk_is_src && ext_static_hit && !(hit && hit_ent[E_STATIC])) begin
                     res_static_ff <= 1'b1;
                     res_fwd_ff <= ext_static_fwd;
                     res_drop_ff <= 1'b0;
                  end
                  if (lk_is_src && blocked) begin
                     evt_ff[EVT_LFAIL] <= 1'b1;
                     idx1_ff[9:0] <= bucket;
                  end
               end
            end
            ST_SEARCH: begin
               if (ptr_ff > LAST_ADR) begin
                  go_ff <= 1'b0;
                  ent_ff <= '0;
                  found_ff <= 1'b0;
                  st_ff <= ST_IDLE;
               end else begin
                  ptr_ff <= ptr_ff + 13'h0001;
                  if (ent_ok(cur_ent)) begin
                     ent_ff <= cur_ent;
                     found_ff <= 1'b1;
                     cnt_ff <= cnt_ff + 13'h0001;
                     st_ff <= ST_SHOLD;
                  end
               end
            end
            ST_SHOLD: begin
               if (rd_ent4) begin
                  found_ff <= 1'b0;
                  st_ff <= ST_SEARCH;
               end
            end
         endcase
         if (age_tick) begin
            age_pend_ff <= 1'b1;
         end
         if (wr_fire && awaddr_ff == ACC_OFS && go_ff && !wd[ACC_GO]) begin
            go_ff <= 1'b0;
            if (st_ff == ST_SEARCH || st_ff == ST_SHOLD) begin
               st_ff <= ST_IDLE;
            end
         end
      end
   end

   assign res_valid = res_valid_ff;
   assign res_hit = res_hit_ff;
   assign res_static = res_static_ff;
   assign res_fwd = res_fwd_ff;
   assign res_drop = res_drop_ff;
endmodule : mlt_lookup_table

// ### tb/mlt_checker_props.sv
// Port assertions for the lookup table
`timescale 1ns/1ps
module mlt_checker
   import mlt_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lk_valid,
   input wire logic lk_ready,
   input wire logic lk_is_src,
   input wire logic ext_static_hit,
   input wire logic res_valid,
   input wire logic res_static
);
   // ------------------------------------------------
   // Sequences and assertions
   // ------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_lk_take;
      lk_valid && lk_ready;
   endsequence
   AST_R_HOLD:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
   AST_B_HOLD:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid lost");
   AST_AR_ANS:
      assert property (s_ar_take |=> s_axi_rvalid) else $error("no read answer");
   AST_UNMAP:
      assert property (s_ar_take and s_axi_araddr == 16'h0500 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_LK_RES:
      assert property (s_lk_take |=> res_valid) else $error("no lookup result");
   AST_RES_CAUSE:
      assert property (res_valid |-> $past(lk_valid && lk_ready)) else $error("stray result");
   AST_CLR:
      assert property ($fell(rst) |-> !lk_ready [*8]) else $error("lookup open during clear");
   AST_EXT_WINS:
      assert property (s_lk_take and !lk_is_src && ext_static_hit |=> res_static) else $error("static lost");
endmodule : mlt_checker
bind mlt_lookup_table mlt_checker chk (.*);

// ### tb/mlt_lk_source.sv
// Lookup request source model
`timescale 1ns/1ps
module mlt_lk_source (
   input wire logic core_clk,
   input wire logic lk_ready,
   output logic lk_valid,
   output logic lk_is_src,
   output logic [47:0] lk_mac,
   output logic [6:0] lk_fid,
   output logic [6:0] lk_src_mask,
   output logic ext_static_hit,
   output logic [6:0] ext_static_fwd,
   output logic hang
);
   initial begin
      lk_valid = 1'b0;
      lk_is_src = 1'b0;
      lk_mac = 48'h0;
      lk_fid = 7'h01;
      lk_src_mask = 7'h00;
      ext_static_hit = 1'b0;
      ext_static_fwd = 7'h00;
      hang = 1'b0;
   end
   // Request held until taken, then MAC and external static hit inverted
   task automatic issue(input logic src, input logic [47:0] mac, input logic [6:0] mask, input logic ehit,
      input logic [6:0] efwd, input int gap);
      logic tk;
      int n;
      repeat (gap) @(posedge core_clk);
      lk_valid <= 1'b1;
      lk_is_src <= src;
      lk_mac <= mac;
      lk_src_mask <= mask;
      ext_static_hit <= ehit;
      ext_static_fwd <= efwd;
      tk = 1'b0;
      n = 0;
      while (!tk) begin
         @(negedge core_clk);
         tk = lk_ready;
         n++;
         hang = n > 6000;
         @(posedge core_clk);
      end
      lk_valid <= 1'b0;
      lk_mac <= ~mac;
      ext_static_hit <= ~ehit;
   endtask : issue
endmodule : mlt_lk_source

// ### tb/tb_top.sv
// Self-checking bench for the lookup table
`timescale 1ns/1ps
module tb_top
   import mlt_pkg::*;
;
   logic core_clk, rst, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, age_tick, hang;
   logic lk_valid, lk_ready, lk_is_src, ext_static_hit, res_valid, res_hit, res_static, res_drop;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [47:0] lk_mac;
   logic [6:0] lk_fid, lk_src_mask, ext_static_fwd, res_fwd;
   logic [31:0] ent [4] = '{32'h8000_0005, 32'h0000_0042, 32'h0003_ABCD, 32'h1234_5678};
   int miscompares, compares;
   mlt_lookup_table uut (.*);
   mlt_lk_source lks (.*);
   always #2 core_clk = ~core_clk;
   always @(posedge hang) begin
      miscompares++;
      end_of_test();
   end
   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   task automatic end_of_test;
      $display("miscompares %0d compares %0d", miscompares, compares);
      if (miscompares == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic guard(inout int n);
      n++;
      if (n > 5000) begin
         miscompares++;
         end_of_test();
      end
   endtask : guard
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      int n;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      n = 0;
      while (!tb) begin
         @(negedge core_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         guard(n);
      end
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rs);
      logic ta, tr;
      int n;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      n = 0;
      while (!tr) begin
         @(negedge core_clk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'b0;
         guard(n);
      end
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic poll(input int b, input logic lvl);
      int n;
      n = 0;
      do begin
         rd(ACC_OFS, v, r);
         guard(n);
      end while (v[b] !== lvl);
   endtask : poll
   task automatic ents(input logic zero);
      for (int i = 0; i < 4; i++) begin
         rd(ENT1_OFS + 16'(4 * i), v, r);
         chk(v, zero ? 32'h0 : ent[i]);
      end
   endtask : ents
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic sc_direct;
      wr(IDX1_OFS, 32'h123);
      wr(ACC_OFS, 32'h86);
      poll(ACC_GO, 1'b0);
      for (int i = 0; i < 4; i++) wr(ENT1_OFS + 16'(4 * i), ent[i]);
      wr(ACC_OFS, 32'h85);
      poll(ACC_GO, 1'b0);
      wr(ENT1_OFS, 32'h5);
      wr(IDX1_OFS, 32'h124);
      wr(ACC_OFS, 32'h85);
      poll(ACC_GO, 1'b0);
      wr(ACC_OFS, 32'h86);
      poll(ACC_GO, 1'b0);
      chk(v & 32'h18, 32'h10);
      ents(1'b1);
      wr(IDX1_OFS, 32'h123);
      wr(ACC_OFS, 32'h86);
      poll(ACC_GO, 1'b0);
      chk(v & 32'h18, 32'h18);
      ents(1'b0);
   endtask : sc_direct
   task automatic sc_search;
      wr(ACC_OFS, 32'h0000_0083);
      poll(4, 1'b1);
      chk(v & 32'h88, 32'h88);
      ents(1'b0);
      poll(ACC_GO, 1'b0);
      chk({19'h0, v[28:16]}, 32'h1);
      ents(1'b1);
      wr(ACC_OFS, 32'h83);
      wr(ACC_OFS, 32'h86);
      rd(ACC_OFS, v, r);
      chk(v & 32'h83, 32'h83);
      wr(ACC_OFS, 32'h3);
      rd(ACC_OFS, v, r);
      chk(v & 32'h80, 32'h0);
      rd(16'h0500, v, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(16'h0500, v);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
   endtask : sc_search
   task automatic lk_chk(input logic [31:0] exp);
      @(negedge core_clk);
      chk({21'h0, res_drop, res_hit, res_valid, res_static, res_fwd}, exp);
   endtask : lk_chk
   task automatic sc_lookup;
      lks.issue(1'b1, 48'h0200_0000_0001, 7'h04, 1'b0, 7'h00, 1);
      lks.issue(1'b0, 48'h0200_0000_0001, 7'h00, 1'b0, 7'h00, 3);
      lk_chk(32'h304);
      lks.issue(1'b0, 48'h0200_0000_0001, 7'h00, 1'b1, 7'h30, 1);
      lk_chk(32'h3B0);
      for (int i = 0; i < 4; i++) begin
         lks.issue(1'b0, 48'h5, 7'h00, 1'b0, 7'h00, 1);
         age_tick <= 1'b1;
         @(posedge core_clk);
         age_tick <= 1'b0;
      end
      lks.issue(1'b0, 48'h0200_0000_0001, 7'h00, 1'b0, 7'h00, 1);
      lk_chk(32'h100);
      wr(ACC_OFS, 32'h86);
      poll(ACC_GO, 1'b0);
      chk(v & 32'h8, 32'h8);
   endtask : sc_lookup
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, age_tick} = 6'h0;
      s_axi_awaddr = 16'h0;
      s_axi_araddr = 16'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      miscompares = 0;
      compares = 0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      sc_direct();
      sc_search();
      sc_lookup();
      end_of_test();
   end
endmodule : tb_top
